// >>> design/eas_core.sv
// Effective address, major state sequencing, accumulator write and carry slice
//
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`include "eas_regs.svh"
module eas_core
    import eas_pkg::*;
(
    input wire logic pclk, // Clock, 50 MHz
    input wire logic presetn, // Asynchronous reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error for unmapped address
    input wire logic [15:0] memory_data_bus, // Word from the memory assembly
    input wire logic interrupt_request, // Interrupt pending pin
    output logic [15:0] memory_output_bus, // Address or data to memory
    output logic [15:0] memory_address_register, // Captured memory address
    output logic address_load_strobe, // Address capture strobe
    output logic sum_to_memory_drive, // Adder drives output bus
    output logic counter_to_memory_drive, // Counter drives output bus
    output logic memory_cycle_request, // Start next memory cycle
    output logic accumulator_write_strobe, // Accumulator write strobe
    output logic carry_state_output, // Carry indicator
    output eas_pkg::eas_mstate_t major_state, // Current major state
    output logic [1:0] timing_phase // Current timing phase
);
    import eas_pkg::*;

    eas_state_t s;
    eas_state_t next_s;

    logic [15:0] ir;
    logic is_alc;
    logic is_jgrp;
    logic is_lda;
    logic is_sta;
    logic is_memref;
    logic is_jump;
    logic is_jsr;
    logic is_isz_dsz;
    logic indirect;
    logic has_e_cycle;
    logic int_pending;
    eas_mstate_t goto_state;
    eas_base_t base_sel;
    eas_oper_t oper_sel;
    logic [15:0] sum;
    logic carry_out;
    logic carry_base;
    logic [15:0] pc_new;
    logic pc_from_sum;
    logic acc_access;
    logic [1:0] acc_idx;

    // Instruction decode from the latched instruction word
    assign ir = s.instruction_register;
    assign is_alc = ir[`EAS_IR_ALC];
    assign is_jgrp = ~is_alc & (ir[14:13] == 2'h0);
    assign is_lda = ~is_alc & (ir[14:13] == 2'h1);
    assign is_sta = ~is_alc & (ir[14:13] == 2'h2);
    assign is_memref = is_jgrp | is_lda | is_sta;
    assign is_jump = is_jgrp & ~ir[12];
    assign is_jsr = is_jgrp & (ir[12:11] == 2'h1);
    assign is_isz_dsz = is_jgrp & ir[12];
    assign indirect = ir[`EAS_IR_IND];
    assign int_pending = s.int_b;

    // Needs-execute drops once both state flip-flops are set (execute)
    assign has_e_cycle = (is_lda | is_sta | is_isz_dsz) & (s.mstate != EAS_EXEC);

    // Major state the coming phase three loads
    always_comb
    begin
        case (s.mstate)
            EAS_FETCH:
            begin
                if (is_memref & indirect)
                    goto_state = EAS_DEFER;
                else if (is_memref & ~indirect & has_e_cycle)
                    goto_state = EAS_EXEC;
                else
                    goto_state = EAS_FETCH;
            end
            EAS_DEFER:
            begin
                if (s.processor_memory_buffer[`EAS_IR_DEFER_MORE])
                    goto_state = EAS_DEFER;
                else if (has_e_cycle)
                    goto_state = EAS_EXEC;
                else
                    goto_state = EAS_FETCH;
            end
            EAS_EXEC: goto_state = int_pending ? EAS_PI : EAS_FETCH;
            default: goto_state = EAS_FETCH;
        endcase
    end

    // Adder input selection per major state
    always_comb
    begin
        base_sel = EAS_BASE_ZERO;
        oper_sel = EAS_OPER_NONE;
        case (s.mstate)
            EAS_FETCH:
            begin
                if (is_memref)
                begin
                    base_sel = eas_base_t'({1'b0, ir[`EAS_IR_MODE_HI:`EAS_IR_MODE_LO]});
                    oper_sel = EAS_OPER_DISP;
                end
                else if (is_alc)
                begin
                    base_sel = EAS_BASE_SRC;
                    oper_sel = EAS_OPER_DST;
                end
            end
            EAS_DEFER: oper_sel = EAS_OPER_BUF;
            EAS_EXEC:
            begin
                if (is_lda)
                    oper_sel = EAS_OPER_BUF;
            end
            default: oper_sel = EAS_OPER_NONE;
        endcase
    end

    eas_sum_unit #(
        .WIDTH(16)
    ) u_sum (
        .base_sel(base_sel),
        .oper_sel(oper_sel),
        .program_counter(s.program_counter),
        .ac2(s.acs[2]),
        .ac3(s.acs[3]),
        .src_value(s.acs[ir[14:13]]),
        .dst_value(s.acd[ir[12:11]]),
        .membuf(s.processor_memory_buffer),
        .defer_word(s.mstate == EAS_DEFER),
        .sum(sum),
        .carry_out(carry_out)
    );

    // Counter value after this cycle: jump target or next word
    always_comb
    begin
        pc_from_sum = is_jump & (goto_state == EAS_FETCH)
            & ((s.mstate == EAS_FETCH) | (s.mstate == EAS_DEFER));
        if (pc_from_sum)
            pc_new = sum;
        else if ((s.mstate == EAS_FETCH) & (goto_state == EAS_FETCH))
            pc_new = s.program_counter + 16'h0001;
        else
            pc_new = s.program_counter;
    end

    // Carry base from the instruction; only arithmetic adds its carry-out
    always_comb
    begin
        case (is_alc ? ir[5:4] : 2'h0)
            2'h1: carry_base = 1'b0;
            2'h2: carry_base = 1'b1;
            2'h3: carry_base = ~s.carry;
            default: carry_base = s.carry;
        endcase
    end

    // Accumulator window of the register map
    assign acc_access = (paddr >= `EAS_OFF_AC0) & (paddr <= `EAS_OFF_AC3) & (paddr[1:0] == 2'h0);
    assign acc_idx = paddr[3:2];

    // Whole next-state function
    always_comb
    begin
        next_s = s;
        next_s.mem_s1 = 1'b0;
        next_s.mem_a = memory_data_bus;
        next_s.mem_b = s.mem_a;
        next_s.int_a = interrupt_request;
        next_s.int_b = s.int_a;
        next_s.address_load_strobe = 1'b0;
        next_s.memory_cycle_request = 1'b0;
        next_s.accumulator_write_strobe = 1'b0;
        next_s.pready = 1'b0;
        next_s.pslverr = 1'b0;

        if (s.run)
        begin
            next_s.phase = s.phase + 2'h1;
            case (s.phase)
                `EAS_PH0:
                begin
                    // Write lands on the trailing edge of the phase-zero strobe
                    if (s.accumulator_write_strobe)
                    begin
                        next_s.acs[s.wsel] = s.result_register;
                        next_s.acd[s.wsel] = s.result_register;
                    end
                end
                `EAS_PH1:
                begin
                    next_s.processor_memory_buffer = s.mem_b;
                    if (s.mstate == EAS_FETCH)
                    begin
                        next_s.instruction_register = s.mem_b;
                        next_s.result_register = s.program_counter + 16'h0001;
                    end
                    else if ((s.mstate == EAS_EXEC) & (base_sel == EAS_BASE_ZERO)
                        & (oper_sel != EAS_OPER_DST))
                        next_s.program_counter = s.program_counter + 16'h0001;
                    if ((s.mstate == EAS_EXEC) & is_sta)
                        next_s.memory_output_bus = s.acd[ir[12:11]];
                end
                `EAS_PH2:
                begin
                    // Address settles on the bus a phase before it is strobed
                    next_s.program_counter = pc_new;
                    next_s.memory_cycle_request = 1'b1;
                    if (goto_state == EAS_FETCH)
                    begin
                        next_s.memory_output_bus = pc_new;
                        next_s.counter_to_memory_drive = ~pc_from_sum;
                        next_s.sum_to_memory_drive = pc_from_sum;
                    end
                    else
                    begin
                        next_s.memory_output_bus = sum;
                        next_s.sum_to_memory_drive = 1'b1;
                    end
                end
                default:
                begin
                    // Drives drop as the strobe rises; the bus is already stable
                    next_s.sum_to_memory_drive = 1'b0;
                    next_s.counter_to_memory_drive = 1'b0;
                    next_s.address_load_strobe = 1'b1;
                    next_s.memory_address_register = s.memory_output_bus;
                    next_s.mstate = goto_state;
                    next_s.carry = carry_base ^ (is_alc & (s.mstate == EAS_FETCH)
                        & carry_out);
                    if ((s.mstate == EAS_EXEC) & is_lda)
                    begin
                        next_s.result_register = sum;
                        next_s.wsel = ir[12:11];
                        next_s.accumulator_write_strobe = 1'b1;
                    end
                    else if ((s.mstate == EAS_FETCH) & is_alc)
                    begin
                        next_s.result_register = sum;
                        next_s.wsel = ir[12:11];
                        next_s.accumulator_write_strobe = 1'b1;
                    end
                    else if ((s.mstate == EAS_FETCH) & is_jsr)
                    begin
                        // Return address already sits in the result register
                        next_s.wsel = 2'h3;
                        next_s.accumulator_write_strobe = 1'b1;
                    end
                end
            endcase
        end

        // APB setup cycle: decode and prepare the answer for the access phase
        if (psel & ~penable)
        begin
            next_s.pready = 1'b1;
            next_s.prdata = 32'h00000000;
            case (paddr)
                `EAS_OFF_CTRL: next_s.prdata[`EAS_CTRL_RUN] = s.run;
                `EAS_OFF_STATUS:
                begin
                    next_s.prdata[`EAS_ST_PHASE_LO +: 2] = s.phase;
                    next_s.prdata[`EAS_ST_MSTATE_LO +: 2] = s.mstate;
                    next_s.prdata[`EAS_ST_CARRY] = s.carry;
                    next_s.prdata[`EAS_ST_RUN] = s.run;
                end
                `EAS_OFF_PC: next_s.prdata[15:0] = s.program_counter;
                `EAS_OFF_MA: next_s.prdata[15:0] = s.memory_address_register;
                `EAS_OFF_RESULT: next_s.prdata[15:0] = s.result_register;
                `EAS_OFF_IR: next_s.prdata[15:0] = s.instruction_register;
                default:
                begin
                    if (acc_access)
                        next_s.prdata[15:0] = s.acd[acc_idx];
                    else
                        next_s.pslverr = 1'b1;
                end
            endcase
        end

        // APB access phase: a write takes effect only at the completing edge
        if (psel & penable & s.pready & pwrite & ~s.pslverr)
        begin
            case (paddr)
                `EAS_OFF_CTRL:
                begin
                    next_s.run = pwdata[`EAS_CTRL_RUN];
                    if (~pwdata[`EAS_CTRL_RUN])
                        next_s.phase = `EAS_PH0;
                end
                `EAS_OFF_PC: next_s.program_counter = pwdata[15:0];
                default:
                begin
                    if (acc_access)
                    begin
                        next_s.acs[acc_idx] = pwdata[15:0];
                        next_s.acd[acc_idx] = pwdata[15:0];
                    end
                end
            endcase
        end
    end

    // Single state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s <= '0;
            s.run <= `EAS_RUN_RST;
            s.program_counter <= `EAS_PC_RST;
            s.mstate <= EAS_FETCH;
        end
        else
        begin
            s <= next_s;
        end
    end

    // Outputs straight from state flip-flops
    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign memory_output_bus = s.memory_output_bus;
    assign memory_address_register = s.memory_address_register;
    assign address_load_strobe = s.address_load_strobe;
    assign sum_to_memory_drive = s.sum_to_memory_drive;
    assign counter_to_memory_drive = s.counter_to_memory_drive;
    assign memory_cycle_request = s.memory_cycle_request;
    assign accumulator_write_strobe = s.accumulator_write_strobe;
    assign carry_state_output = s.carry;
    assign major_state = s.mstate;
    assign timing_phase = s.phase;
endmodule : eas_core

// >>> common/eas_regs.svh
// Offsets, field positions, reset values and timing counts for the address/state slice
`ifndef EAS_REGS_SVH
`define EAS_REGS_SVH

// Register byte offsets
`define EAS_OFF_CTRL 8'h00
`define EAS_OFF_STATUS 8'h04
`define EAS_OFF_PC 8'h08
`define EAS_OFF_MA 8'h0c
`define EAS_OFF_RESULT 8'h10
`define EAS_OFF_IR 8'h14
`define EAS_OFF_AC0 8'h20
`define EAS_OFF_AC3 8'h2c

// Field positions
`define EAS_CTRL_RUN 0
`define EAS_ST_PHASE_LO 0
`define EAS_ST_MSTATE_LO 2
`define EAS_ST_CARRY 4
`define EAS_ST_RUN 5
`define EAS_IR_ALC 15
`define EAS_IR_IND 10
`define EAS_IR_MODE_HI 9
`define EAS_IR_MODE_LO 8
`define EAS_IR_SIGN 7
`define EAS_IR_DEFER_MORE 15

// Reset values
`define EAS_PC_RST 16'h0000
`define EAS_RUN_RST 1'b0

// Timing: clocks per machine cycle phase index limits
`define EAS_PH0 2'h0
`define EAS_PH1 2'h1
`define EAS_PH2 2'h2
`define EAS_PH3 2'h3

`endif

// >>> common/eas_pkg.sv
// Types shared by the address/state slice
package eas_pkg;

    typedef enum logic [1:0] {
        EAS_FETCH = 2'h0,
        EAS_PI = 2'h1,
        EAS_DEFER = 2'h2,
        EAS_EXEC = 2'h3
    } eas_mstate_t;

    typedef enum logic [2:0] {
        EAS_BASE_ZERO = 3'h0,
        EAS_BASE_PC = 3'h1,
        EAS_BASE_AC2 = 3'h2,
        EAS_BASE_AC3 = 3'h3,
        EAS_BASE_SRC = 3'h4
    } eas_base_t;

    typedef enum logic [1:0] {
        EAS_OPER_NONE = 2'h0,
        EAS_OPER_DISP = 2'h1,
        EAS_OPER_BUF = 2'h2,
        EAS_OPER_DST = 2'h3
    } eas_oper_t;

    typedef struct packed {
        logic mem_s1;
        logic [15:0] mem_a;
        logic [15:0] mem_b;
        logic int_a;
        logic int_b;
        logic run;
        logic [1:0] phase;
        eas_mstate_t mstate;
        logic [15:0] program_counter;
        logic [15:0] instruction_register;
        logic [15:0] processor_memory_buffer;
        logic [15:0] result_register;
        logic [15:0] memory_address_register;
        logic [15:0] memory_output_bus;
        logic [3:0][15:0] acs;
        logic [3:0][15:0] acd;
        logic [1:0] wsel;
        logic carry;
        logic sum_to_memory_drive;
        logic counter_to_memory_drive;
        logic address_load_strobe;
        logic memory_cycle_request;
        logic accumulator_write_strobe;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } eas_state_t;

endpackage : eas_pkg

// >>> design/eas_sum_unit.sv
// Base and operand multiplexers feeding the sixteen-bit adder
`timescale 1ns/100ps
`include "eas_regs.svh"
module eas_sum_unit
    import eas_pkg::*;
#(
    parameter int WIDTH = 16
)
(
    input wire eas_pkg::eas_base_t base_sel, // Base multiplexer select
    input wire eas_pkg::eas_oper_t oper_sel, // Operand multiplexer select
    input wire logic [WIDTH-1:0] program_counter, // Counter value
    input wire logic [WIDTH-1:0] ac2, // Accumulator two
    input wire logic [WIDTH-1:0] ac3, // Accumulator three
    input wire logic [WIDTH-1:0] src_value, // Source accumulator
    input wire logic [WIDTH-1:0] dst_value, // Destination accumulator
    input wire logic [WIDTH-1:0] membuf, // Processor memory buffer
    input wire logic defer_word, // Use buffer as 15-bit address
    output logic [WIDTH-1:0] sum, // Adder output
    output logic carry_out // Adder carry
);
    logic page_zero;
    logic negative;
    logic [WIDTH-1:0] base;
    logic [WIDTH-1:0] oper;

    // Sign of the displacement; page zero never extends
    assign page_zero = (membuf[`EAS_IR_MODE_HI:`EAS_IR_MODE_LO] == 2'h0);
    assign negative = membuf[`EAS_IR_SIGN] & ~page_zero;

    // Base multiplexer
    always_comb
    begin
        case (base_sel)
            EAS_BASE_PC: base = program_counter;
            EAS_BASE_AC2: base = ac2;
            EAS_BASE_AC3: base = ac3;
            EAS_BASE_SRC: base = src_value;
            default: base = '0;
        endcase
    end

    // Operand multiplexer; low half is the displacement byte
    always_comb
    begin
        case (oper_sel)
            EAS_OPER_DISP: oper = {{(WIDTH-8){negative}}, membuf[7:0]};
            EAS_OPER_BUF: oper = defer_word ? {1'b0, membuf[WIDTH-2:0]} : membuf;
            EAS_OPER_DST: oper = dst_value;
            default: oper = '0;
        endcase
    end

    // Full-width add keeps the carry as a seventeenth bit
    assign {carry_out, sum} = {1'b0, base} + {1'b0, oper};
endmodule : eas_sum_unit

// >>> verification/eas_core_props.sv
// Port checker for the address/state slice
`timescale 1ns/100ps
module eas_core_props
    import eas_pkg::*;
(
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pready, // APB ready
    input wire logic [15:0] memory_output_bus, // Bus to memory
    input wire logic [15:0] memory_address_register, // Captured address
    input wire logic address_load_strobe, // Address strobe
    input wire logic sum_to_memory_drive, // Adder drive
    input wire logic counter_to_memory_drive, // Counter drive
    input wire logic memory_cycle_request, // Cycle start
    input wire logic accumulator_write_strobe, // Accumulator write
    input wire logic carry_state_output, // Carry indicator
    input wire eas_pkg::eas_mstate_t major_state, // Major state
    input wire logic [1:0] timing_phase // Phase
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Strobe must follow a cycle in which the bus was already driven
    strobe_after_drive_a: assert property (
        address_load_strobe |-> $past(sum_to_memory_drive || counter_to_memory_drive))
        else $error("address strobe without drive");
    ma_capture_a: assert property (
        address_load_strobe |-> memory_address_register == $past(memory_output_bus))
        else $error("address register missed bus value");
    req_phase_a: assert property (
        memory_cycle_request |-> timing_phase == 2'h3)
        else $error("cycle request outside phase three");
    drive_phase_a: assert property (
        (sum_to_memory_drive || counter_to_memory_drive)
        |-> timing_phase == 2'h3 && !(sum_to_memory_drive && counter_to_memory_drive))
        else $error("bus drive wrong phase or contended");
    exec_entry_a: assert property (
        (major_state == EAS_EXEC && $past(major_state) != EAS_EXEC)
        |-> $past(timing_phase) == 2'h3)
        else $error("execute entered off phase three");
    exec_leave_a: assert property (
        (major_state == EAS_EXEC && timing_phase == 2'h3) |=> major_state != EAS_EXEC)
        else $error("execute lasted beyond one cycle");
    // An execute cycle that hands over to fetch presents the counter
    exec_counter_a: assert property (
        (major_state == EAS_EXEC && memory_cycle_request) ##1 (major_state == EAS_FETCH)
        |-> $past(counter_to_memory_drive))
        else $error("execute end without counter drive");
    pi_entry_a: assert property (
        (major_state == EAS_PI && $past(major_state) != EAS_PI)
        |-> $past(major_state) == EAS_EXEC && $past(timing_phase) == 2'h3)
        else $error("interrupt state entered off execute end");
    write_phase_a: assert property (
        accumulator_write_strobe |-> timing_phase == 2'h0 && $past(timing_phase) == 2'h3)
        else $error("accumulator write outside phase zero");
    carry_moment_a: assert property (
        $changed(carry_state_output) |-> $past(timing_phase) == 2'h3)
        else $error("carry changed off phase three");
    apb_ready_a: assert property ((psel && !penable) |=> pready ##1 !pready)
        else $error("ready not a single cycle after setup");
endmodule : eas_core_props

bind eas_core eas_core_props i_props (.pclk, .presetn, .psel, .penable, .pready,
    .memory_output_bus, .memory_address_register, .address_load_strobe, .sum_to_memory_drive,
    .counter_to_memory_drive, .memory_cycle_request, .accumulator_write_strobe,
    .carry_state_output, .major_state, .timing_phase);

// >>> verification/eas_mem_model.sv
// Core memory assembly model on the far side of the slice
`timescale 1ns/100ps
module eas_mem_model
(
    input wire logic pclk, // Clock
    input wire logic [15:0] memory_output_bus, // Address from processor
    input wire logic sum_to_memory_drive, // Adder drives bus
    input wire logic counter_to_memory_drive, // Counter drives bus
    output logic [15:0] memory_data_bus // Word read out
);
    logic [15:0] prog [16]; // Program words at the lowest addresses
    logic [15:0] held = 16'h0000;
    wire drv = sum_to_memory_drive | counter_to_memory_drive;

    // Data words elsewhere follow a fixed address pattern
    function automatic logic [15:0] word_at(input logic [15:0] a);
        return (a < 16'h0010) ? prog[a[3:0]] : a ^ 16'h25c3;
    endfunction : word_at

    initial
    begin
        foreach (prog[i]) prog[i] = 16'h0000;
    end

    // Memory buffer keeps the last word between cycles, as a core output register does
    always @(posedge pclk)
    begin
        if (drv) held <= word_at(memory_output_bus);
    end
    assign memory_data_bus = drv ? word_at(memory_output_bus) : held;
endmodule : eas_mem_model

// >>> verification/tb_effective_address_and_state_sequencing.sv
// Self-checking bench for the address/state slice
`timescale 1ns/100ps
`include "eas_regs.svh"
module tb_effective_address_and_state_sequencing;
    import eas_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, err, interrupt_request = 1'b0;
    logic [15:0] memory_data_bus, memory_output_bus, memory_address_register;
    logic address_load_strobe, sum_to_memory_drive, counter_to_memory_drive;
    logic memory_cycle_request, accumulator_write_strobe, carry_state_output;
    eas_mstate_t major_state;
    logic [1:0] timing_phase;
    int n_fail = 0, n_compared = 0;
    logic [10:0] corner [4] = '{11'h0ff, 11'h180, 11'h27f, 11'h780};

    // Free-running 50 MHz clock
    always #10 pclk = ~pclk;

    eas_core i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .memory_data_bus, .interrupt_request, .memory_output_bus,
        .memory_address_register, .address_load_strobe, .sum_to_memory_drive,
        .counter_to_memory_drive, .memory_cycle_request, .accumulator_write_strobe,
        .carry_state_output, .major_state, .timing_phase);
    eas_mem_model i_mem (.pclk, .memory_output_bus, .sum_to_memory_drive,
        .counter_to_memory_drive, .memory_data_bus);

    task automatic finish_test();
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : finish_test

    task automatic fail(input string m);
        n_fail++;
        $display("[ERR] %0t %s", $time, m);
    endtask : fail

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_compared++;
        if (got !== exp) fail(m);
    endtask : chk

    // One APB transfer; the request stands until ready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++)
        begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 16) fail("bus timeout");
        if (i == 16) finish_test();
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Run one instruction, then jump to 2 and on to 0; stop after its write
    task automatic run_prog(input logic [15:0] ins);
        int i;
        i_mem.prog[0] = ins;
        i_mem.prog[1] = 16'h0002;
        // The stop lands as word 2 is read; a restart first executes that held word
        i_mem.prog[2] = 16'h0000;
        apb(1'b1, `EAS_OFF_PC, 32'h0);
        apb(1'b1, `EAS_OFF_CTRL, 32'h1);
        for (i = 0; i < 400; i++)
        begin
            @(posedge pclk);
            if (accumulator_write_strobe === 1'b1) break;
        end
        if (i == 400) fail("no accumulator write");
        if (i == 400) finish_test();
        apb(1'b1, `EAS_OFF_CTRL, 32'h0);
    endtask : run_prog

    function automatic logic [15:0] mem_word(input logic [15:0] a);
        return (a < 16'h0010) ? i_mem.prog[a[3:0]] : a ^ 16'h25c3;
    endfunction : mem_word

    // Expected load data: base plus extended displacement, then defer chain
    function automatic logic [15:0] lda_exp(input logic [15:0] ins, a2, a3);
        logic [15:0] ea, w;
        // Page zero and counter bases are both zero: the instruction sits at 0
        ea = (ins[9:8] == 2'd2) ? a2 : (ins[9:8] == 2'd3) ? a3 : 16'h0;
        ea = ea + {{8{ins[7] && ins[9:8] != 2'b00}}, ins[7:0]};
        for (int k = 0; k < 4 && ins[10]; k++)
        begin
            w = mem_word(ea);
            ea = {1'b0, w[14:0]};
            if (!w[15]) break;
        end
        return mem_word(ea);
    endfunction : lda_exp

    initial
    begin
        logic [15:0] ins, v [4];
        logic [16:0] sum;
        logic [1:0] s, d;
        logic c;
        void'($urandom(32'h4f685aa5));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `EAS_OFF_PC, 32'h0);
        chk(q, 32'h0, "counter reset value");
        apb(1'b0, `EAS_OFF_STATUS, 32'h0);
        chk(q, 32'h0, "status reset value");
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped access not refused");
        $display("test reset done");
        for (int t = 0; t < 12; t++)
        begin
            ins = {1'b0, 2'b01, 2'(t), 11'($urandom)};
            if (t < 4) ins[10:0] = corner[t];
            v[2] = 16'($urandom);
            v[3] = 16'($urandom);
            // Last load ends its execute cycle with an interrupt pending
            interrupt_request <= (t == 11);
            apb(1'b1, `EAS_OFF_AC0 + 8'h08, {16'h0, v[2]});
            apb(1'b1, `EAS_OFF_AC3, {16'h0, v[3]});
            run_prog(ins);
            apb(1'b0, `EAS_OFF_AC0 + {4'h0, ins[12:11], 2'b00}, 32'h0);
            chk(q, {16'h0, lda_exp(ins, v[2], v[3])}, "load result");
        end
        $display("test load done");
        for (int t = 0; t < 8; t++)
        begin
            for (int j = 0; j < 4; j++)
            begin
                v[j] = (t == 0) ? 16'hffff : 16'($urandom);
                apb(1'b1, `EAS_OFF_AC0 + 8'(j * 4), {16'h0, v[j]});
            end
            s = 2'($urandom);
            d = 2'($urandom);
            apb(1'b0, `EAS_OFF_STATUS, 32'h0);
            c = q[`EAS_ST_CARRY];
            run_prog({1'b1, s, d, 5'h00, 2'(t), 4'h0});
            sum = {1'b0, v[s]} + {1'b0, v[d]};
            c = (t % 4 == 0) ? c : (t % 4 == 1) ? 1'b0 : (t % 4 == 2) ? 1'b1 : ~c;
            apb(1'b0, `EAS_OFF_AC0 + {4'h0, d, 2'b00}, 32'h0);
            chk(q, {16'h0, sum[15:0]}, "sum result");
            apb(1'b0, `EAS_OFF_STATUS, 32'h0);
            chk({31'h0, q[`EAS_ST_CARRY]}, {31'h0, c ^ sum[16]}, "carry value");
            chk({31'h0, carry_state_output}, {31'h0, c ^ sum[16]}, "carry light");
        end
        $display("test carry done");
        finish_test();
    end
endmodule : tb_effective_address_and_state_sequencing
